// ==== core/rsx_defines.svh ====
// constants for the rotate, subtract-with-borrow and decrement-skip datapath
//
// Contract
// - rotate left through carry: carry into bit 0, bit 7 to carry, write memory.
// - same left rotate through carry, result to accumulator, memory unchanged.
// - plain right rotate, bit 0 wraps to bit 7, write memory, carry kept.
// - plain right rotate into accumulator only, memory unchanged.
// - rotate right through carry: carry into bit 7, bit 0 to carry, write memory.
// - same right rotate through carry, result to accumulator, memory unchanged.
// - accumulator plus inverted memory plus carry, result to accumulator.
// - same subtract-with-borrow sum, result written back to memory.
// - decrement memory, write back, skip next instruction when result is zero.
// - skip drops prefetched instruction, adds one dummy cycle; otherwise one cycle.
// - decrement into accumulator only, memory untouched, skip when result zero.
`ifndef RSX_DEFINES_SVH
`define RSX_DEFINES_SVH

`define RSX_DATA_W 8
`define RSX_OP_W 4
`define RSX_ACC_RESET 8'h00
`define RSX_MSB 7
`define RSX_SKIP_CYCLES 2
`define RSX_PLAIN_CYCLES 1

`endif

// ==== core/rsx_pkg.sv ====
// types for the rotate, subtract-with-borrow and decrement-skip datapath
`include "rsx_defines.svh"
package rsx_pkg;
  typedef enum logic [3:0] {
    OP_NONE = 4'h0,
    OP_ROT_LEFT_CARRY_MEM = 4'h1,
    OP_ROT_LEFT_CARRY_ACC = 4'h2,
    OP_ROT_RIGHT_MEM = 4'h3,
    OP_ROT_RIGHT_ACC = 4'h4,
    OP_ROT_RIGHT_CARRY_MEM = 4'h5,
    OP_ROT_RIGHT_CARRY_ACC = 4'h6,
    OP_SUB_BORROW_ACC = 4'h7,
    OP_SUB_BORROW_MEM = 4'h8,
    OP_DEC_SKIP_MEM = 4'h9,
    OP_DEC_SKIP_ACC = 4'hA
  } rsx_op_t;

  typedef enum logic [1:0] {
    ST_RUN = 2'b01,
    ST_DUMMY = 2'b10
  } rsx_state_t;
endpackage : rsx_pkg

// ==== core/rsx_exec.sv ====
// execution datapath: rotates, subtract-with-borrow, decrement-and-skip
`timescale 1ns/1ps
`include "rsx_defines.svh"
module rsx_exec (
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic EXEC_VALID,
  input wire logic [3:0] EXEC_OP,
  input wire logic [7:0] MEM_RDATA,
  input wire logic [7:0] ACC_IN,
  input wire logic CARRY_IN,
  output logic [7:0] RESULT,
  output logic MEM_WE,
  output logic ACC_WE,
  output logic CARRY_OUT,
  output logic CARRY_WE,
  output logic AUX_CARRY_OUT,
  output logic OVERFLOW_OUT,
  output logic ZERO_OUT,
  output logic ARITH_FLAGS_WE,
  output logic FETCH_DISCARD,
  output logic EXEC_READY
);

  // ----------------------------------------
  // combinational result
  // ----------------------------------------
  rsx_pkg::rsx_op_t op;
  logic [7:0] res;
  logic c_new;
  logic c_we;
  logic m_we;
  logic a_we;
  logic ac_new;
  logic ov_new;
  logic z_new;
  logic f_we;
  logic skip;
  logic [8:0] sum;
  logic [4:0] low_sum;
  logic [7:0] mem_inv;
  logic [7:0] dec_val;
  logic go;

  assign op = rsx_pkg::rsx_op_t'(EXEC_OP);
  assign mem_inv = ~MEM_RDATA;
  assign dec_val = MEM_RDATA - 8'h01;
  assign sum = {1'b0, ACC_IN} + {1'b0, mem_inv} + {8'h00, CARRY_IN};
  assign low_sum = {1'b0, ACC_IN[3:0]} + {1'b0, mem_inv[3:0]} + {4'h0, CARRY_IN};

  always_comb begin
    res = MEM_RDATA;
    c_new = CARRY_IN;
    c_we = 1'b0;
    m_we = 1'b0;
    a_we = 1'b0;
    f_we = 1'b0;
    skip = 1'b0;
    ac_new = low_sum[4];
    ov_new = (ACC_IN[7] == mem_inv[7]) && (sum[7] != ACC_IN[7]);
    z_new = (sum[7:0] == 8'h00);
    unique case (op)
      rsx_pkg::OP_ROT_LEFT_CARRY_MEM: begin
        res = {MEM_RDATA[6:0], CARRY_IN};
        c_new = MEM_RDATA[`RSX_MSB];
        c_we = 1'b1;
        m_we = 1'b1;
      end
      rsx_pkg::OP_ROT_LEFT_CARRY_ACC: begin
        res = {MEM_RDATA[6:0], CARRY_IN};
        c_new = MEM_RDATA[`RSX_MSB];
        c_we = 1'b1;
        a_we = 1'b1;
      end
      rsx_pkg::OP_ROT_RIGHT_MEM: begin
        res = {MEM_RDATA[0], MEM_RDATA[7:1]};
        m_we = 1'b1;
      end
      rsx_pkg::OP_ROT_RIGHT_ACC: begin
        res = {MEM_RDATA[0], MEM_RDATA[7:1]};
        a_we = 1'b1;
      end
      rsx_pkg::OP_ROT_RIGHT_CARRY_MEM: begin
        res = {CARRY_IN, MEM_RDATA[7:1]};
        c_new = MEM_RDATA[0];
        c_we = 1'b1;
        m_we = 1'b1;
      end
      rsx_pkg::OP_ROT_RIGHT_CARRY_ACC: begin
        res = {CARRY_IN, MEM_RDATA[7:1]};
        c_new = MEM_RDATA[0];
        c_we = 1'b1;
        a_we = 1'b1;
      end
      rsx_pkg::OP_SUB_BORROW_ACC: begin
        res = sum[7:0];
        c_new = sum[8];
        c_we = 1'b1;
        f_we = 1'b1;
        a_we = 1'b1;
      end
      rsx_pkg::OP_SUB_BORROW_MEM: begin
        res = sum[7:0];
        c_new = sum[8];
        c_we = 1'b1;
        f_we = 1'b1;
        m_we = 1'b1;
      end
      // decrement memory and skip on zero
      rsx_pkg::OP_DEC_SKIP_MEM: begin
        res = dec_val;
        m_we = 1'b1;
        skip = (dec_val == 8'h00);
      end
      // decrement into accumulator and skip on zero
      rsx_pkg::OP_DEC_SKIP_ACC: begin
        res = dec_val;
        a_we = 1'b1;
        skip = (dec_val == 8'h00);
      end
      default: begin
        res = MEM_RDATA;
      end
    endcase
  end

  // ----------------------------------------
  // skip sequencer
  // ----------------------------------------
  rsx_pkg::rsx_state_t state_reg;
  rsx_pkg::rsx_state_t state_next;

  // accepted only while not in the dummy slot
  assign go = EXEC_VALID && (state_reg == rsx_pkg::ST_RUN);
  assign EXEC_READY = (state_reg == rsx_pkg::ST_RUN);

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      rsx_pkg::ST_RUN: begin
        if (go && skip) begin
          state_next = rsx_pkg::ST_DUMMY;
        end
      end
      rsx_pkg::ST_DUMMY: begin
        state_next = rsx_pkg::ST_RUN;
      end
      default: begin
        state_next = rsx_pkg::ST_RUN;
      end
    endcase
  end

  // ----------------------------------------
  // registered outputs
  // ----------------------------------------
  logic [7:0] result_reg;
  logic [7:0] result_next;
  logic mem_we_reg;
  logic mem_we_next;
  logic acc_we_reg;
  logic acc_we_next;
  logic carry_reg;
  logic carry_next;
  logic carry_we_reg;
  logic carry_we_next;
  logic ac_reg;
  logic ac_next;
  logic ov_reg;
  logic ov_next;
  logic z_reg;
  logic z_next;
  logic fwe_reg;
  logic fwe_next;
  logic discard_reg;
  logic discard_next;

  always_comb begin
    result_next = go ? res : result_reg;
    mem_we_next = go && m_we;
    acc_we_next = go && a_we;
    carry_next = go ? c_new : carry_reg;
    carry_we_next = go && c_we;
    ac_next = go ? ac_new : ac_reg;
    ov_next = go ? ov_new : ov_reg;
    z_next = go ? z_new : z_reg;
    fwe_next = go && f_we;
    discard_next = go && skip;
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state_reg <= rsx_pkg::ST_RUN;
      result_reg <= `RSX_ACC_RESET;
      mem_we_reg <= 1'b0;
      acc_we_reg <= 1'b0;
      carry_reg <= 1'b0;
      carry_we_reg <= 1'b0;
      ac_reg <= 1'b0;
      ov_reg <= 1'b0;
      z_reg <= 1'b0;
      fwe_reg <= 1'b0;
      discard_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      result_reg <= result_next;
      mem_we_reg <= mem_we_next;
      acc_we_reg <= acc_we_next;
      carry_reg <= carry_next;
      carry_we_reg <= carry_we_next;
      ac_reg <= ac_next;
      ov_reg <= ov_next;
      z_reg <= z_next;
      fwe_reg <= fwe_next;
      discard_reg <= discard_next;
    end
  end

  assign RESULT = result_reg;
  assign MEM_WE = mem_we_reg;
  assign ACC_WE = acc_we_reg;
  assign CARRY_OUT = carry_reg;
  assign CARRY_WE = carry_we_reg;
  assign AUX_CARRY_OUT = ac_reg;
  assign OVERFLOW_OUT = ov_reg;
  assign ZERO_OUT = z_reg;
  assign ARITH_FLAGS_WE = fwe_reg;
  assign FETCH_DISCARD = discard_reg;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!ARST_N);

  chk_rlc_mem: assert property (
    go && op == rsx_pkg::OP_ROT_LEFT_CARRY_MEM |=>
    RESULT == {$past(MEM_RDATA[6:0]), $past(CARRY_IN)} && CARRY_OUT == $past(MEM_RDATA[7]) && MEM_WE && !ACC_WE)
    else $error("left rotate through carry to memory wrong");
  chk_rlc_acc: assert property (
    go && op == rsx_pkg::OP_ROT_LEFT_CARRY_ACC |=>
    ACC_WE && !MEM_WE && CARRY_WE && CARRY_OUT == $past(MEM_RDATA[7]))
    else $error("left rotate through carry to accumulator wrong");
  chk_rr_mem: assert property (
    go && op == rsx_pkg::OP_ROT_RIGHT_MEM |=>
    RESULT == {$past(MEM_RDATA[0]), $past(MEM_RDATA[7:1])} && MEM_WE && !CARRY_WE)
    else $error("right rotate to memory wrong");
  chk_rr_acc: assert property (
    go && op == rsx_pkg::OP_ROT_RIGHT_ACC |=> ACC_WE && !MEM_WE && !CARRY_WE && !ARITH_FLAGS_WE)
    else $error("right rotate to accumulator wrong");
  chk_rrc_mem: assert property (
    go && op == rsx_pkg::OP_ROT_RIGHT_CARRY_MEM |=>
    RESULT == {$past(CARRY_IN), $past(MEM_RDATA[7:1])} && CARRY_OUT == $past(MEM_RDATA[0]))
    else $error("right rotate through carry to memory wrong");
  chk_rrc_acc: assert property (
    go && op == rsx_pkg::OP_ROT_RIGHT_CARRY_ACC |=> ACC_WE && !MEM_WE && CARRY_OUT == $past(MEM_RDATA[0]))
    else $error("right rotate through carry to accumulator wrong");
  chk_sbc_acc: assert property (
    go && op == rsx_pkg::OP_SUB_BORROW_ACC |=>
    RESULT == 8'($past(ACC_IN) - $past(MEM_RDATA) - {7'h00, !$past(CARRY_IN)}) && ACC_WE && ARITH_FLAGS_WE)
    else $error("borrow subtract to accumulator wrong");
  chk_sbc_mem: assert property (
    go && op == rsx_pkg::OP_SUB_BORROW_MEM |=> MEM_WE && !ACC_WE && ZERO_OUT == (RESULT == 8'h00))
    else $error("borrow subtract to memory wrong");
  chk_dec_mem: assert property (
    go && op == rsx_pkg::OP_DEC_SKIP_MEM |=>
    RESULT == 8'($past(MEM_RDATA) - 8'h01) && MEM_WE && FETCH_DISCARD == (RESULT == 8'h00))
    else $error("decrement skip to memory wrong");
  chk_skip_slot: assert property (
    go && skip |=> FETCH_DISCARD && !EXEC_READY ##1 EXEC_READY && !FETCH_DISCARD)
    else $error("skip must take exactly one dummy cycle");
  chk_dec_acc: assert property (
    go && op == rsx_pkg::OP_DEC_SKIP_ACC |=> ACC_WE && !MEM_WE && !CARRY_WE)
    else $error("decrement skip to accumulator wrong");
  chk_flag_scope: assert property (
    ARITH_FLAGS_WE |-> $past(op == rsx_pkg::OP_SUB_BORROW_ACC || op == rsx_pkg::OP_SUB_BORROW_MEM))
    else $error("arithmetic flags written by wrong operation");

  cov_skip: cover property (go && op == rsx_pkg::OP_DEC_SKIP_MEM && skip);
  cov_noskip: cover property (go && op == rsx_pkg::OP_DEC_SKIP_ACC && !skip);
  cov_sub_carry: cover property (go && op == rsx_pkg::OP_SUB_BORROW_ACC && sum[8]);
  cov_rot: cover property (go && op == rsx_pkg::OP_ROT_LEFT_CARRY_MEM ##1 go && op == rsx_pkg::OP_ROT_RIGHT_MEM);

endmodule : rsx_exec

// ==== tb/rsx_core_model.sv ====
// core model: data memory byte, accumulator and carry flag around the datapath
`timescale 1ns/1ps
module rsx_core_model (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ld,
  input wire logic [7:0] ld_mem,
  input wire logic [7:0] ld_acc,
  input wire logic ld_c,
  input wire logic [7:0] result,
  input wire logic mem_we,
  input wire logic acc_we,
  input wire logic carry_out,
  input wire logic carry_we,
  output logic [7:0] mem_reg,
  output logic [7:0] acc_reg,
  output logic carry_reg
);
  // ----------------------------------------
  // storage, loaded by the bench or by strobes
  // ----------------------------------------
  // outside a bench load only a strobe may change a value, so a stray write shows up
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mem_reg <= 8'h00;
      acc_reg <= 8'h00;
      carry_reg <= 1'b0;
    end else if (ld) begin
      mem_reg <= ld_mem;
      acc_reg <= ld_acc;
      carry_reg <= ld_c;
    end else begin
      if (mem_we) mem_reg <= result;
      if (acc_we) acc_reg <= result;
      if (carry_we) carry_reg <= carry_out;
    end
  end
endmodule : rsx_core_model

// ==== tb/tb_rotate_subtract_skip_exec.sv ====
// self-checking bench for the rotate, subtract-with-borrow and decrement-skip datapath
`timescale 1ns/1ps
module tb_rotate_subtract_skip_exec;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic exec_valid = 1'b0;
  logic [3:0] exec_op = 4'h0;
  logic ld = 1'b0;
  logic [7:0] ld_mem = 8'h00;
  logic [7:0] ld_acc = 8'h00;
  logic ld_c = 1'b0;
  logic [7:0] result, mem_q, acc_q;
  logic c_q, mem_we, acc_we, c_out, c_we, ac_out, ov_out, z_out, fl_we, discard, ready;
  int n_mismatch = 0;
  int compares = 0;

  always #5 clk = ~clk;

  rsx_exec DUT (.CLK(clk), .ARST_N(arst_n), .EXEC_VALID(exec_valid), .EXEC_OP(exec_op), .MEM_RDATA(mem_q),
    .ACC_IN(acc_q), .CARRY_IN(c_q), .RESULT(result), .MEM_WE(mem_we), .ACC_WE(acc_we), .CARRY_OUT(c_out),
    .CARRY_WE(c_we), .AUX_CARRY_OUT(ac_out), .OVERFLOW_OUT(ov_out), .ZERO_OUT(z_out),
    .ARITH_FLAGS_WE(fl_we), .FETCH_DISCARD(discard), .EXEC_READY(ready));
  rsx_core_model core (.clk(clk), .arst_n(arst_n), .ld(ld), .ld_mem(ld_mem), .ld_acc(ld_acc), .ld_c(ld_c),
    .result(result), .mem_we(mem_we), .acc_we(acc_we), .carry_out(c_out), .carry_we(c_we),
    .mem_reg(mem_q), .acc_reg(acc_q), .carry_reg(c_q));

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // load the core, then one op; returns in the strobe cycle
  // nv keeps a rotate request up into the following cycle, which may be a dummy slot
  task automatic issue(input logic [3:0] op, input logic [7:0] m, input logic [7:0] a, input logic c,
    input logic nv = 1'b0);
    @(posedge clk);
    #1;
    ld = 1'b1;
    ld_mem = m;
    ld_acc = a;
    ld_c = c;
    @(posedge clk);
    #1;
    ld = 1'b0;
    chk({8'h00, ready}, 9'h001);
    exec_valid = 1'b1;
    exec_op = op;
    @(posedge clk);
    #1;
    exec_valid = nv;
    exec_op = nv ? 4'h3 : op;
  endtask : issue

  task automatic conclude();
    if (n_mismatch == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : conclude

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_rotate();
    logic [7:0] m;
    logic [7:0] e;
    logic c;
    logic nc;
    // bit 7 and bit 0 differ so every carry path is visible
    m = 8'h96;
    for (int k = 1; k <= 6; k++) begin
      for (int ci = 0; ci < 2; ci++) begin
        c = ci[0];
        if (k <= 2) begin
          e = {m[6:0], c};
          nc = m[7];
        end else if (k <= 4) begin
          e = {m[0], m[7:1]};
          nc = c;
        end else begin
          e = {c, m[7:1]};
          nc = m[0];
        end
        issue(k[3:0], m, 8'h3C, c);
        chk({8'h00, fl_we}, 9'h000);
        @(posedge clk);
        #1;
        chk({1'b0, k[0] ? mem_q : acc_q}, {1'b0, e});
        chk({1'b0, k[0] ? acc_q : mem_q}, {1'b0, k[0] ? 8'h3C : m});
        chk({8'h00, c_q}, {8'h00, nc});
      end
    end
  endtask : t_rotate

  task automatic t_subtract();
    logic [7:0] av[4] = '{8'h50, 8'h20, 8'h80, 8'h10};
    logic [7:0] mv[4] = '{8'h20, 8'h50, 8'h01, 8'h10};
    logic cv[4] = '{1'b1, 1'b0, 1'b1, 1'b1};
    logic [8:0] s;
    logic [4:0] lo;
    logic ov;
    for (int j = 0; j < 8; j++) begin
      s = {1'b0, av[j%4]} + {1'b0, ~mv[j%4]} + 9'(cv[j%4]);
      lo = {1'b0, av[j%4][3:0]} + {1'b0, ~mv[j%4][3:0]} + 5'(cv[j%4]);
      ov = (av[j%4][7] == ~mv[j%4][7]) && (s[7] != av[j%4][7]);
      issue(j[2] ? 4'h8 : 4'h7, mv[j%4], av[j%4], cv[j%4]);
      chk({4'h0, fl_we, c_out, ac_out, ov_out, z_out}, {4'h0, 1'b1, s[8], lo[4], ov, s[7:0] == 8'h00});
      @(posedge clk);
      #1;
      chk({1'b0, j[2] ? mem_q : acc_q}, {1'b0, s[7:0]});
      chk({1'b0, j[2] ? acc_q : mem_q}, {1'b0, j[2] ? av[j%4] : mv[j%4]});
      chk({7'h00, ac_out, ov_out}, {7'h00, lo[4], ov});
    end
  endtask : t_subtract

  task automatic t_skip(input logic [3:0] op, input logic [7:0] m);
    logic z;
    z = (m == 8'h01);
    // on a skip a rotate request sits in the dummy cycle and must be ignored
    issue(op, m, 8'h5A, 1'b1, z);
    chk({7'h00, discard, ready}, {7'h00, z, !z});
    @(posedge clk);
    #1;
    exec_valid = 1'b0;
    chk({6'h00, mem_we, acc_we, discard}, 9'h000);
    chk({1'b0, op[0] ? mem_q : acc_q}, {1'b0, m - 8'h01});
    chk({1'b0, op[0] ? acc_q : mem_q}, {1'b0, op[0] ? 8'h5A : m});
    chk({8'h00, c_q}, 9'h001);
  endtask : t_skip

  // reset in the dummy slot must clear the result, strobes and flags at once and raise ready
  task automatic t_reset();
    issue(4'h9, 8'h01, 8'h5A, 1'b1);
    arst_n = 1'b0;
    #1;
    chk({result, ready}, 9'h001);
    chk({4'h0, mem_we, discard, z_out, ac_out, ov_out}, 9'h000);
    repeat (2) @(posedge clk);
    #1;
    arst_n = 1'b1;
    @(posedge clk);
    #1;
    chk({mem_q, ready}, 9'h001);
  endtask : t_reset

  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial begin
    repeat (8) @(posedge clk);
    #1;
    arst_n = 1'b1;
    t_rotate();
    t_subtract();
    t_skip(4'h9, 8'h01);
    t_skip(4'h9, 8'h00);
    t_skip(4'hA, 8'h01);
    t_skip(4'hA, 8'h80);
    t_reset();
    conclude();
  end

  // the whole run needs about 110 cycles
  initial begin
    #20000;
    n_mismatch++;
    conclude();
  end
endmodule : tb_rotate_subtract_skip_exec
